// File: design/operand_and_target_formation.sv
// operand widening, jump target, pointer mapping and state timing
// What this block does
// - zero-extended 16-bit immediate gets upper sixteen bits zero.
// - ones-extended 16-bit immediate gets upper sixteen bits one.
// - short increment constant only ever one, two or four.
// - 11-bit target stays within the 2 KB block of next instruction.
// - 16-bit target stays within the 64 KB region, upper byte kept.
// - 24-bit target replaces the whole program counter.
// - relative offset is signed 8-bit, added to next instruction address.
// - data pointer is the low sixteen bits of the extended pointer.
// - 16-bit direct address always lands in region zero.
// - sign extension copies the top bit into all added bits.
// - two phases from halving the clock; a state spans both.
// - 24-bit internal address, only 16 or 17 bits on pins.
// - a configuration bit selects binary or source mode.
`timescale 1ns/1ns
module operand_and_target_formation
  import opform_pkg::*;
#(
  parameter int EXT_PINS = 16
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // configuration
  input wire logic SOURCE_MODE_I,
  input wire logic WIDE_PINS_I,
  // immediate operand request
  input wire opform_pkg::imm_kind_t IMM_KIND_I,
  input wire logic [15:0] IMM_FIELD_I,
  input wire logic [1:0] SHORT_FIELD_I,
  // target request
  input wire opform_pkg::target_kind_t TGT_KIND_I,
  input wire logic [23:0] NEXT_PC_I,
  input wire logic [23:0] ADDR_FIELD_I,
  input wire logic [15:0] DIRECT_FIELD_I,
  // pointer access
  input wire logic DPL_WRITE_I,
  input wire logic XPTR_WRITE_I,
  input wire logic [23:0] PTR_DATA_I,
  // operand results
  output logic [31:0] OPERAND_O,
  output logic [2:0] SHORT_VALUE_O,
  output logic SHORT_BAD_O,
  // target results
  output logic [23:0] TARGET_O,
  output logic TARGET_VALID_O,
  output logic [23:0] DIRECT_ADDR_O,
  output logic [16:0] EXT_ADDR_O,
  // pointer and mode
  output logic [15:0] DATA_POINTER_LOW_O,
  output logic [23:0] EXTENDED_DATA_POINTER_O,
  output logic SOURCE_MODE_O,
  // timing
  output logic PHASE_ONE_O,
  output logic PHASE_TWO_O,
  output logic STATE_END_O
);
  import opform_pkg::*;

  // the pin address is 16 or 17 bits; any other width has no wiring behind it
  if (EXT_PINS != 16 && EXT_PINS != 17)
  begin
    $error("EXT_PINS must be 16 or 17");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic [2:0] short_mag(input logic [1:0] enc);
    unique case (short_enc_t'(enc))
      SHORT_ENC_ONE: short_mag = SHORT_ONE;
      SHORT_ENC_TWO: short_mag = SHORT_TWO;
      SHORT_ENC_FOUR: short_mag = SHORT_FOUR;
      // the spare code still yields a legal size; it is flagged on its own output
      SHORT_ENC_BAD: short_mag = SHORT_ONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic [31:0] operand_reg, operand_next;
  logic [2:0] short_reg, short_next;
  logic short_bad_reg, short_bad_next;
  logic [23:0] target_reg, target_next;
  logic target_valid_reg, target_valid_next;
  logic [23:0] direct_reg, direct_next;
  logic [16:0] ext_reg, ext_next;
  logic [23:0] xptr_reg, xptr_next;
  logic mode_reg, mode_next;
  logic mode_s1_reg, mode_s2_reg;
  logic wide_s1_reg, wide_s2_reg;

  always_comb
  begin
    unique case (IMM_KIND_I)
      IMM_ZERO: operand_next = {UPPER_ZERO, IMM_FIELD_I};
      IMM_ONES: operand_next = {UPPER_ONES, IMM_FIELD_I};
      IMM_SIGN8: operand_next = sext8(IMM_FIELD_I[7:0]);
      IMM_SIGN16: operand_next = sext16(IMM_FIELD_I);
    endcase
    short_next = short_mag(SHORT_FIELD_I);
    short_bad_next = (short_enc_t'(SHORT_FIELD_I) == SHORT_ENC_BAD);
  end

  always_comb
  begin
    target_valid_next = 1'b1;
    unique case (TGT_KIND_I)
      TGT_BLOCK: target_next = {NEXT_PC_I[23:BLOCK_W], ADDR_FIELD_I[BLOCK_W-1:0]};
      TGT_REGION: target_next = {NEXT_PC_I[23:REGION_W], ADDR_FIELD_I[REGION_W-1:0]};
      TGT_FULL: target_next = ADDR_FIELD_I;
      // the widened offset is cut back to the counter width on purpose
      TGT_REL: target_next = NEXT_PC_I + 24'(sext8(ADDR_FIELD_I[7:0]));
      default:
      begin
        target_next = target_reg;
        target_valid_next = 1'b0;
      end
    endcase
    direct_next = {REGION_ZERO, DIRECT_FIELD_I};
    // only the pins in use carry address; the top pin idles low when narrow
    ext_next = {(wide_s2_reg && EXT_PINS == 17) ? target_next[16] : 1'b0,
                target_next[15:0]};
  end

  always_comb
  begin
    xptr_next = xptr_reg;
    // a full write wins, so a low-half write in the same cycle cannot tear it
    if (XPTR_WRITE_I)
    begin
      xptr_next = PTR_DATA_I;
    end
    else if (DPL_WRITE_I)
    begin
      xptr_next = {xptr_reg[23:16], PTR_DATA_I[15:0]};
    end
    mode_next = mode_s2_reg;
  end

  // mode and pin width are straps from outside, so synchronise them
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      operand_reg <= 32'h00000000;
      short_reg <= SHORT_ONE;
      short_bad_reg <= 1'b0;
      target_reg <= 24'h000000;
      target_valid_reg <= 1'b0;
      direct_reg <= 24'h000000;
      ext_reg <= 17'h00000;
      xptr_reg <= XPTR_RESET;
      mode_reg <= 1'b0;
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      wide_s1_reg <= 1'b0;
      wide_s2_reg <= 1'b0;
    end
    else
    begin
      operand_reg <= operand_next;
      short_reg <= short_next;
      short_bad_reg <= short_bad_next;
      target_reg <= target_next;
      target_valid_reg <= target_valid_next;
      direct_reg <= direct_next;
      ext_reg <= ext_next;
      xptr_reg <= xptr_next;
      mode_reg <= mode_next;
      mode_s1_reg <= SOURCE_MODE_I;
      mode_s2_reg <= mode_s1_reg;
      wide_s1_reg <= WIDE_PINS_I;
      wide_s2_reg <= wide_s1_reg;
    end
  end

  assign OPERAND_O = operand_reg;
  assign SHORT_VALUE_O = short_reg;
  assign SHORT_BAD_O = short_bad_reg;
  assign TARGET_O = target_reg;
  assign TARGET_VALID_O = target_valid_reg;
  assign DIRECT_ADDR_O = direct_reg;
  assign EXT_ADDR_O = ext_reg;
  assign DATA_POINTER_LOW_O = xptr_reg[15:0];
  assign EXTENDED_DATA_POINTER_O = xptr_reg;
  assign SOURCE_MODE_O = mode_reg;

  phase_gen u_phase (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .phase_one_o(PHASE_ONE_O),
    .phase_two_o(PHASE_TWO_O),
    .state_end_o(STATE_END_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // operand widening
  zero_ext_a: assert property (IMM_KIND_I == IMM_ZERO |=>
    OPERAND_O == {16'h0000, $past(IMM_FIELD_I)})
    else $error("zero extension wrong");
  ones_ext_a: assert property (IMM_KIND_I == IMM_ONES |=>
    OPERAND_O[31:16] == 16'hFFFF && OPERAND_O[15:0] == $past(IMM_FIELD_I))
    else $error("ones extension wrong");
  sign_ext_a: assert property (IMM_KIND_I == IMM_SIGN8 |=>
    OPERAND_O[31:8] == {24{OPERAND_O[7]}} && OPERAND_O[7:0] == $past(IMM_FIELD_I[7:0]))
    else $error("sign extension wrong");
  sign_wide_a: assert property (IMM_KIND_I == IMM_SIGN16 |=>
    OPERAND_O == {{16{$past(IMM_FIELD_I[15])}}, $past(IMM_FIELD_I)})
    else $error("word sign extension wrong");

  // short constant: legal codes give a power of two, the spare code is flagged
  short_range_a: assert property (##1 SHORT_VALUE_O inside {3'h1, 3'h2, 3'h4})
    else $error("short constant out of range");
  short_map_a: assert property (SHORT_FIELD_I != 2'h3 |=>
    SHORT_VALUE_O == (3'h1 << $past(SHORT_FIELD_I)) && !SHORT_BAD_O)
    else $error("short constant mapped wrong");
  short_bad_a: assert property (SHORT_FIELD_I == 2'h3 |=>
    SHORT_BAD_O && SHORT_VALUE_O == 3'h1)
    else $error("spare short code not flagged");

  // jump targets, all but the full one taken against the next-instruction address
  block_keep_a: assert property (TGT_KIND_I == TGT_BLOCK |=>
    TARGET_O[23:11] == $past(NEXT_PC_I[23:11])
    && TARGET_O[10:0] == $past(ADDR_FIELD_I[10:0]))
    else $error("block target left its block");
  region_keep_a: assert property (TGT_KIND_I == TGT_REGION |=>
    TARGET_O[23:16] == $past(NEXT_PC_I[23:16]))
    else $error("region target left its region");
  region_low_a: assert property (TGT_KIND_I == TGT_REGION |=>
    TARGET_O[15:0] == $past(ADDR_FIELD_I[15:0]))
    else $error("region target low bits wrong");
  full_tgt_a: assert property (TGT_KIND_I == TGT_FULL |=>
    TARGET_O == $past(ADDR_FIELD_I))
    else $error("full target wrong");
  target_valid_a: assert property (TGT_KIND_I != TGT_NONE |=> TARGET_VALID_O)
    else $error("formed target not marked valid");
  // an idle cycle keeps the last target for whoever still reads it
  target_hold_a: assert property (TGT_KIND_I == TGT_NONE |=>
    !TARGET_VALID_O && $stable(TARGET_O))
    else $error("idle target did not hold");
  rel_tgt_a: assert property (TGT_KIND_I == TGT_REL && ADDR_FIELD_I[7] |=>
    TARGET_O == $past(NEXT_PC_I) - (24'h000100 - {16'h0000, $past(ADDR_FIELD_I[7:0])}))
    else $error("backward branch wrong");
  rel_fwd_a: assert property (TGT_KIND_I == TGT_REL && !ADDR_FIELD_I[7] |=>
    TARGET_O == $past(NEXT_PC_I) + {16'h0000, $past(ADDR_FIELD_I[7:0])})
    else $error("forward branch wrong");
  direct_zero_a: assert property (##1 DIRECT_ADDR_O == {8'h00, $past(DIRECT_FIELD_I)})
    else $error("direct address outside region zero");

  // pin address
  ext_pins_a: assert property (!wide_s2_reg |=> EXT_ADDR_O[16] == 1'b0)
    else $error("narrow pins drive top bit");
  ext_wide_a: assert property (wide_s2_reg && EXT_PINS == 17 |=>
    EXT_ADDR_O[16] == TARGET_O[16])
    else $error("wide pins lost the top address bit");
  ext_low_a: assert property (##1 EXT_ADDR_O[15:0] == TARGET_O[15:0])
    else $error("pin address differs from target");

  // pointer halves share one store
  dp_low_a: assert property (DPL_WRITE_I && !XPTR_WRITE_I |=>
    DATA_POINTER_LOW_O == $past(PTR_DATA_I[15:0])
    && EXTENDED_DATA_POINTER_O[23:16] == $past(EXTENDED_DATA_POINTER_O[23:16]))
    else $error("data pointer not mapped to low half");
  xptr_full_a: assert property (XPTR_WRITE_I |=>
    EXTENDED_DATA_POINTER_O == $past(PTR_DATA_I)
    && DATA_POINTER_LOW_O == $past(PTR_DATA_I[15:0]))
    else $error("full pointer write lost");
  xptr_hold_a: assert property (!XPTR_WRITE_I && !DPL_WRITE_I |=>
    $stable(EXTENDED_DATA_POINTER_O))
    else $error("pointer changed without a write");

  // mode strap and state timing
  mode_follow_a: assert property ($rose(SOURCE_MODE_I) ##1 SOURCE_MODE_I[*2] |=>
    SOURCE_MODE_O)
    else $error("mode did not follow strap");
  mode_clear_a: assert property ($fell(SOURCE_MODE_I) ##1 (!SOURCE_MODE_I)[*2] |=>
    !SOURCE_MODE_O)
    else $error("mode did not drop with strap");
  phase_pair_a: assert property (PHASE_ONE_O |=> PHASE_TWO_O && STATE_END_O)
    else $error("state did not close after phase one");

  cov_rel_c: cover property (TGT_KIND_I == TGT_REL ##1 TARGET_VALID_O);
  cov_dpl_c: cover property (DPL_WRITE_I ##1 XPTR_WRITE_I);
  cov_ones_c: cover property (IMM_KIND_I == IMM_ONES ##1 IMM_KIND_I == IMM_SIGN16);
  cov_bad_c: cover property (SHORT_FIELD_I == 2'h3 ##1 SHORT_BAD_O);
  cov_wide_c: cover property (wide_s2_reg && TGT_KIND_I == TGT_REL ##1 EXT_ADDR_O[16]);
endmodule

// File: design/opform_pkg.sv
// constants shared by the operand and target formation logic
package opform_pkg;
  localparam int ADDR_W = 24;
  localparam int WORD_W = 32;
  localparam int IMM_W = 16;
  localparam int BLOCK_W = 11;
  localparam int REGION_W = 16;
  localparam int REL_W = 8;
  localparam int EXT_ADDR_W = 17;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [15:0] UPPER_ONES = 16'hFFFF;
  localparam logic [7:0] REGION_ZERO = 8'h00;
  localparam logic [2:0] SHORT_ONE = 3'h1;
  localparam logic [2:0] SHORT_TWO = 3'h2;
  localparam logic [2:0] SHORT_FOUR = 3'h4;
  localparam logic [23:0] XPTR_RESET = 24'h000000;
  localparam logic PHASE_RESET = 1'h0;
  typedef enum logic [1:0] {SHORT_ENC_ONE, SHORT_ENC_TWO, SHORT_ENC_FOUR, SHORT_ENC_BAD} short_enc_t;
  typedef enum logic [2:0] {TGT_BLOCK, TGT_REGION, TGT_FULL, TGT_REL, TGT_NONE} target_kind_t;
  typedef enum logic [1:0] {IMM_ZERO, IMM_ONES, IMM_SIGN8, IMM_SIGN16} imm_kind_t;
endpackage

// File: design/phase_gen.sv
// two internal phases made by halving the crystal input
`timescale 1ns/1ns
module phase_gen
  import opform_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic phase_one_o,
  output logic phase_two_o,
  output logic state_end_o
);
  logic phase_reg;
  logic phase_next;

  always_comb
  begin
    phase_next = ~phase_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= PHASE_RESET;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  assign phase_one_o = ~phase_reg;
  assign phase_two_o = phase_reg;
  assign state_end_o = phase_reg; // one state spans both phases

  phases_alternate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    phase_one_o |=> phase_two_o ##1 phase_one_o)
    else $error("phases do not alternate");
endmodule

// File: tb/fetch_model.sv
// fetch stage stand-in that hands on the next-instruction address
`timescale 1ns/1ns
module fetch_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [23:0] load_pc_i,
  output logic [23:0] next_pc_o
);
  logic [23:0] pc_reg;
  // whole 24-bit values only, so no reserved bit is ever set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_reg <= 24'h000000;
    else if (load_i)
      pc_reg <= load_pc_i;
  end
  assign next_pc_o = pc_reg;
endmodule

// File: tb/tb_operand_and_target_formation.sv
// self-checking bench for operand widening and target formation
`timescale 1ns/1ns
module tb_operand_and_target_formation;
  import opform_pkg::*;
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
  logic clk, rst, src, wide, dpl, xwr, ld, tvalid, sbad, smode, p_one, p_two, send;
  imm_kind_t ik;
  target_kind_t tk;
  logic [15:0] imm, df, plow;
  logic [1:0] sf;
  logic [23:0] af, pd, lpc, npc, tgt, daddr, eptr;
  logic [31:0] operand;
  logic [2:0] sval;
  logic [16:0] eaddr;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  fetch_model fetch (.clk_i(clk), .rst_i(rst), .load_i(ld), .load_pc_i(lpc), .next_pc_o(npc));
  operand_and_target_formation #(.EXT_PINS(17)) DUT (.CLK_I(clk), .RST_I(rst),
    .SOURCE_MODE_I(src), .WIDE_PINS_I(wide), .IMM_KIND_I(ik), .IMM_FIELD_I(imm),
    .SHORT_FIELD_I(sf), .TGT_KIND_I(tk), .NEXT_PC_I(npc), .ADDR_FIELD_I(af),
    .DIRECT_FIELD_I(df), .DPL_WRITE_I(dpl), .XPTR_WRITE_I(xwr), .PTR_DATA_I(pd),
    .OPERAND_O(operand), .SHORT_VALUE_O(sval), .SHORT_BAD_O(sbad), .TARGET_O(tgt),
    .TARGET_VALID_O(tvalid), .DIRECT_ADDR_O(daddr), .EXT_ADDR_O(eaddr),
    .DATA_POINTER_LOW_O(plow), .EXTENDED_DATA_POINTER_O(eptr), .SOURCE_MODE_O(smode),
    .PHASE_ONE_O(p_one), .PHASE_TWO_O(p_two), .STATE_END_O(send));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cut a hang short well past the 66 or so cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("short_rst", 3'h1, sval)
    `CHK("phase_rst", 1'b1, p_one)
    `CHK("ptr_rst", XPTR_RESET, eptr)
    rst = 1'b0;
  endtask
  task automatic t_imm();
    logic [15:0] v [2] = '{16'h8A80, 16'h7F7F};
    logic [31:0] e;
    for (int j = 0; j < 2; j++)
      for (int k = 0; k < 4; k++)
      begin
        imm = v[j];
        ik = imm_kind_t'(k);
        sf = 2'(k);
        step(1);
        case (k)
          0: e = {UPPER_ZERO, imm};
          1: e = {UPPER_ONES, imm};
          2: e = {{24{imm[7]}}, imm[7:0]};
          default: e = {{16{imm[15]}}, imm};
        endcase
        `CHK("operand", e, operand)
        `CHK("short", (k == 3) ? SHORT_ONE : 3'(1 << k), sval)
        `CHK("short_bad", k == 3, sbad)
      end
  endtask
  // every target kind against one counter value; NONE must hold the last target
  task automatic t_tgt(input logic [23:0] pc, input logic [23:0] f);
    logic [23:0] e;
    ld = 1'b1;
    lpc = pc;
    af = f;
    df = f[15:0];
    step(1);
    ld = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      tk = target_kind_t'(k);
      step(1);
      case (k)
        0: e = {pc[23:11], f[10:0]};
        1: e = {pc[23:16], f[15:0]};
        2: e = f;
        3: e = pc + {{16{f[7]}}, f[7:0]};
        default: e = e;
      endcase
      `CHK("target", e, tgt)
      `CHK("valid", k != 4, tvalid)
      `CHK("direct", {REGION_ZERO, f[15:0]}, daddr)
      if (k != 4)
        `CHK("pin_addr", wide ? e[16:0] : {1'b0, e[15:0]}, eaddr)
    end
  endtask
  // third write sets both strobes: the full write has to win
  task automatic t_ptr();
    logic [23:0] d [3] = '{24'hA1B2C3, 24'h775A5A, 24'h0F1E2D};
    logic [23:0] e [3] = '{24'hA1B2C3, 24'hA15A5A, 24'h0F1E2D};
    for (int k = 0; k < 3; k++)
    begin
      pd = d[k];
      xwr = (k != 1);
      dpl = (k != 0);
      step(1);
      xwr = 1'b0;
      dpl = 1'b0;
      step(1);
      `CHK("ext_ptr", e[k], eptr)
      `CHK("ptr_low", e[k][15:0], plow)
    end
  endtask
  task automatic t_phase();
    logic p;
    `CHK("phase_pair", 1'b1, p_one ^ p_two)
    p = p_one;
    for (int k = 0; k < 4; k++)
    begin
      step(1);
      `CHK("phase_one", ~p, p_one)
      `CHK("phase_two", p, p_two)
      `CHK("state_end", p, send)
      p = ~p;
    end
  endtask
  task automatic t_mode();
    src = 1'b1;
    wide = 1'b1;
    step(4);
    `CHK("mode_set", 1'b1, smode)
    src = 1'b0;
    step(1);
    `CHK("mode_lag", 1'b1, smode)
    step(3);
    `CHK("mode_clear", 1'b0, smode)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, src, wide, dpl, xwr, ld, imm, df, sf, af, pd, lpc} = '0;
    rst = 1'b1;
    ik = IMM_ZERO;
    tk = TGT_NONE;
    step(16);
    t_reset();
    t_imm();
    t_tgt(24'h123456, 24'hABCDEF);
    t_tgt(24'h00FFF0, 24'h3D007F);
    t_tgt(24'h3D0010, 24'h000080);
    t_ptr();
    t_phase();
    t_mode();
    t_tgt(24'h3D0010, 24'h3D5678);
    report_and_stop();
  end
endmodule
